// *** logic/smis_pkg.sv ***
// Package for the system-control masked fault status block: register map,
// field positions, reset values, AXI4-Lite codes and the state carriers.
// Assumes a single 25 MHz clock with a synchronous, active-low reset.
//
// Functional notes
// - Each masked bit is raw AND mask, bit 1 also needs brown-out-to-reset cleared; the masked bits drive the interrupt.
// - Writing one to a masked bit clears it and the matching raw bit.
// - Bit 6 sets when the PLL ready timer expires; write one clears it.
// - Bit 5 sets when the regulator current-limit indication asserts; write one clears.
// - Bit 4 sets when the internal oscillator monitor reports a fault; write one clears.
// - Bit 3 sets when a main oscillator fault is detected; write one clears.
// - Bit 2 sets when the regulator output is out of regulation; write one clears.
// - Bit 1 interrupts only with its mask set and brown-out-to-reset cleared.
// - Bit 0 sets when the PLL stops oscillating; write one clears it.
// - Seven read-write mask bits at positions 0 to 6, reset to zero.
package smis_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int          SMIS_ADDR_W    = 12;
  localparam int          SMIS_DATA_W    = 32;
  localparam int          SMIS_NUM_EVT   = 7;
  localparam logic [11:0] SMIS_OFF_BOCTL = 12'h0030;  // Brown-out control.
  localparam logic [11:0] SMIS_OFF_RAW   = 12'h0050;  // Raw fault status, read only.
  localparam logic [11:0] SMIS_OFF_MASK  = 12'h0054;  // Fault interrupt mask.
  localparam logic [11:0] SMIS_OFF_MSC   = 12'h0058;  // Masked status and clear.

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int SMIS_BIT_PLL_LOCK  = 6;
  localparam int SMIS_BIT_CUR_LIMIT = 5;
  localparam int SMIS_BIT_INT_OSC   = 4;
  localparam int SMIS_BIT_MAIN_OSC  = 3;
  localparam int SMIS_BIT_REG_UNREG = 2;
  localparam int SMIS_BIT_BROWNOUT  = 1;
  localparam int SMIS_BIT_PLL_FAULT = 0;
  localparam int SMIS_BIT_BO_RESET  = 1;  // Brown-out-to-reset select in control reg.

  localparam logic [6:0] SMIS_MASK_RST  = 7'h00;
  localparam logic [6:0] SMIS_RAW_RST   = 7'h00;
  localparam logic       SMIS_BOSEL_RST = 1'b0;

  // ---------------------------------------------------------------------
  // AXI4-Lite response codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] SMIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SMIS_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  // Fault detector inputs, one level per source.
  typedef struct packed {
    logic pll_lock_ready;
    logic current_limit;
    logic int_osc_fault;
    logic main_osc_fault;
    logic regulator_unreg;
    logic brownout;
    logic pll_fault;
  } smis_evt_t;

  // State of the top module, apart from the synchroniser and raw status banks.
  typedef struct packed {
    logic [6:0]  fault_irq_mask;
    logic        brownout_to_reset_select;
    logic        aw_got;
    logic        w_got;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
  } smis_state_t;

endpackage

// *** logic/smis_sync.sv ***
// Three-stage synchroniser bank for the fault detector levels.
// Assumes the detector outputs are asynchronous to aclk.
`timescale 1ns/1ps
module smis_sync
  import smis_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         aclk,     // System clock.
  input  wire logic         aresetn,  // Synchronous reset, active low.
  input  wire logic [W-1:0] async_i,  // Raw detector levels.
  output logic      [W-1:0] level_o   // Filtered level, valid once two stages agree.
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } smis_sync_state_t;

  smis_sync_state_t q;
  smis_sync_state_t d;

  // A change is accepted only when stages two and three agree.
  always_comb begin
    d     = q;
    d.s1  = async_i;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.lvl;

endmodule

// *** logic/smis_flag.sv ***
// Bank of sticky flags with set and clear strobes.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module smis_flag
  import smis_pkg::*;
#(
  parameter int         W   = 7,
  parameter logic [6:0] RST = SMIS_RAW_RST
) (
  input  wire logic         aclk,     // System clock.
  input  wire logic         aresetn,  // Synchronous reset, active low.
  input  wire logic [W-1:0] set_i,    // Set request per bit, level.
  input  wire logic [W-1:0] clr_i,    // Clear request per bit, one-cycle pulse.
  output logic      [W-1:0] flags_o   // Current flags, registered.
);

  typedef struct packed {
    logic [W-1:0] flags;
  } smis_flag_state_t;

  smis_flag_state_t q;
  smis_flag_state_t d;

  // Set beats clear so an event in the clearing cycle is not lost.
  always_comb begin
    d       = q;
    d.flags = (q.flags & ~clr_i) | set_i;
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q.flags <= RST[W-1:0];
    end else begin
      q <= d;
    end
  end

  assign flags_o = q.flags;

endmodule

// *** logic/smis_top.sv ***
// Top of the masked fault status block: AXI4-Lite slave, mask and
// brown-out control registers, masked status with write-one-to-clear,
// and the level interrupt toward the processor.
// Assumes fault detectors drive asynchronous levels and that software
// reaches the registers through one AXI4-Lite master.
`timescale 1ns/1ps
module smis_top
  import smis_pkg::*;
#(
  parameter int NUM_EVT = SMIS_NUM_EVT,
  parameter int ADDR_W  = SMIS_ADDR_W
) (
  input  wire logic              aclk,           // System clock, 25 MHz.
  input  wire logic              aresetn,        // Synchronous reset, active low.
  input  wire smis_evt_t         fault_evt,      // Fault detector levels.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address.
  input  wire logic [2:0]        s_axi_awprot,   // Write protection, unused.
  input  wire logic              s_axi_awvalid,  // Write address valid.
  output logic                   s_axi_awready,  // Write address ready.
  input  wire logic [31:0]       s_axi_wdata,    // Write data.
  input  wire logic [3:0]        s_axi_wstrb,    // Write byte strobes.
  input  wire logic              s_axi_wvalid,   // Write data valid.
  output logic                   s_axi_wready,   // Write data ready.
  output logic [1:0]             s_axi_bresp,    // Write response code.
  output logic                   s_axi_bvalid,   // Write response valid.
  input  wire logic              s_axi_bready,   // Write response ready.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address.
  input  wire logic [2:0]        s_axi_arprot,   // Read protection, unused.
  input  wire logic              s_axi_arvalid,  // Read address valid.
  output logic                   s_axi_arready,  // Read address ready.
  output logic [31:0]            s_axi_rdata,    // Read data.
  output logic [1:0]             s_axi_rresp,    // Read response code.
  output logic                   s_axi_rvalid,   // Read data valid.
  input  wire logic              s_axi_rready,   // Read data ready.
  output logic                   fault_irq       // Interrupt request, level.
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------

  // Word-aligned address match; the two low bits are byte lanes only.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [11:0]       off);
    addr_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // Masked status: raw AND mask, with brown-out held off in reset mode.
  function automatic logic [6:0] masked_of(input logic [6:0] raw,
                                           input logic [6:0] mask,
                                           input logic       bo_sel);
    logic [6:0] m;
    m                   = raw & mask;
    m[SMIS_BIT_BROWNOUT] = m[SMIS_BIT_BROWNOUT] & ~bo_sel;
    masked_of           = m;
  endfunction

  // True when the address is one of the mapped registers.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    addr_mapped = addr_hit(addr, SMIS_OFF_BOCTL) | addr_hit(addr, SMIS_OFF_RAW) |
                  addr_hit(addr, SMIS_OFF_MASK)  | addr_hit(addr, SMIS_OFF_MSC);
  endfunction

  // ---------------------------------------------------------------------
  // Event capture
  // ---------------------------------------------------------------------

  logic [NUM_EVT-1:0] evt_level;
  logic [NUM_EVT-1:0] raw_fault_status;
  logic [NUM_EVT-1:0] raw_clr;
  logic [NUM_EVT-1:0] evt_vec;

  // Pack the detector levels into status bit order, bit 6 down to bit 0.
  always_comb begin
    evt_vec                     = '0;
    evt_vec[SMIS_BIT_PLL_LOCK]  = fault_evt.pll_lock_ready;
    evt_vec[SMIS_BIT_CUR_LIMIT] = fault_evt.current_limit;
    evt_vec[SMIS_BIT_INT_OSC]   = fault_evt.int_osc_fault;
    evt_vec[SMIS_BIT_MAIN_OSC]  = fault_evt.main_osc_fault;
    evt_vec[SMIS_BIT_REG_UNREG] = fault_evt.regulator_unreg;
    evt_vec[SMIS_BIT_BROWNOUT]  = fault_evt.brownout;
    evt_vec[SMIS_BIT_PLL_FAULT] = fault_evt.pll_fault;
  end

  // Detector levels come from other clock sources, so filter them first.
  smis_sync #(
    .W (NUM_EVT)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_i (evt_vec),
    .level_o (evt_level)
  );

  // Raw status bits. While a detector still reports its condition the
  // bit stays set, so a clear only sticks once the condition is gone.
  smis_flag #(
    .W   (NUM_EVT),
    .RST (SMIS_RAW_RST)
  ) u_raw (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_i   (evt_level),
    .clr_i   (raw_clr),
    .flags_o (raw_fault_status)
  );

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------

  smis_state_t q;
  smis_state_t d;

  logic       wr_fire;
  logic       wr_lane0;
  logic [6:0] wr_bits;
  logic [6:0] masked_now;

  // Current masked view, used by reads and the interrupt.
  assign masked_now = masked_of(raw_fault_status, q.fault_irq_mask,
                                q.brownout_to_reset_select);

  // A write is carried out once both address and data are held and the
  // previous response has been taken.
  assign wr_fire  = q.aw_got & q.w_got & ~q.bvalid;
  assign wr_lane0 = q.w_strb[0];
  assign wr_bits  = q.w_data[6:0];

  // Write-one-to-clear on the masked register also clears the raw bit.
  // The clear goes to the raw bank whatever the mask; zeros do nothing.
  always_comb begin
    raw_clr = '0;
    if (wr_fire && wr_lane0 && addr_hit(q.aw_addr, SMIS_OFF_MSC)) begin
      raw_clr = wr_bits[NUM_EVT-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // Next-state logic: bus slave, registers and interrupt
  // ---------------------------------------------------------------------
  always_comb begin
    d = q;

    // Write address channel: hold one address until the write completes.
    if (s_axi_awvalid && q.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr[11:0];
    end

    // Write data channel, taken independently of the address.
    if (s_axi_wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end

    // Register update and response once both halves are in.
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = addr_mapped(q.aw_addr) ? SMIS_RESP_OKAY : SMIS_RESP_SLVERR;
      if (wr_lane0 && addr_hit(q.aw_addr, SMIS_OFF_MASK)) begin
        d.fault_irq_mask = wr_bits;
      end
      if (wr_lane0 && addr_hit(q.aw_addr, SMIS_OFF_BOCTL)) begin
        d.brownout_to_reset_select = q.w_data[SMIS_BIT_BO_RESET];
      end
      // Upper bits of the masked register are ignored on write.
    end

    // Response stands until the master takes it.
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.bresp  = SMIS_RESP_OKAY;
    end

    // Ready only while the matching half is still missing and no
    // response is pending; this keeps one write in flight at a time.
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready  = ~d.w_got & ~d.bvalid;

    // Read channel: data come from the state before the taking edge.
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = SMIS_RESP_OKAY;
      d.rdata  = '0;  // Reserved bits read as zero.
      if (addr_hit(s_axi_araddr, SMIS_OFF_MSC)) begin
        d.rdata[6:0] = masked_now;
      end else if (addr_hit(s_axi_araddr, SMIS_OFF_RAW)) begin
        d.rdata[6:0] = raw_fault_status;
      end else if (addr_hit(s_axi_araddr, SMIS_OFF_MASK)) begin
        d.rdata[6:0] = q.fault_irq_mask;
      end else if (addr_hit(s_axi_araddr, SMIS_OFF_BOCTL)) begin
        d.rdata[SMIS_BIT_BO_RESET] = q.brownout_to_reset_select;
      end else begin
        d.rresp = SMIS_RESP_SLVERR;
      end
    end

    // Read data stand until the master takes them.
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    d.arready = ~d.rvalid;

    // Level interrupt, high while any masked bit is set.
    d.irq = |masked_now;
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------

  // Synchronous reset; every field takes a constant.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q                          <= '0;
      q.fault_irq_mask           <= SMIS_MASK_RST;
      q.brownout_to_reset_select <= SMIS_BOSEL_RST;
      q.bresp                    <= SMIS_RESP_OKAY;
      q.rresp                    <= SMIS_RESP_OKAY;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign fault_irq     = q.irq;

endmodule

// *** test/smis_monitor.sv ***
// Checker for the masked fault status block, bound to its top module.
// Assumes one clock domain and a synchronous, active-low reset.
`timescale 1ns/1ps
module smis_monitor
  import smis_pkg::*;
#(
  parameter int ADDR_W = SMIS_ADDR_W
) (
  input wire logic              aclk,           // Clock.
  input wire logic              aresetn,        // Reset, active low.
  input wire smis_evt_t         fault_evt,      // Detector levels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address.
  input wire logic              s_axi_awvalid,  // Write address valid.
  input wire logic              s_axi_awready,  // Write address ready.
  input wire logic [31:0]       s_axi_wdata,    // Write data.
  input wire logic [3:0]        s_axi_wstrb,    // Write strobes.
  input wire logic              s_axi_wvalid,   // Write data valid.
  input wire logic              s_axi_wready,   // Write data ready.
  input wire logic [1:0]        s_axi_bresp,    // Write response.
  input wire logic              s_axi_bvalid,   // Write response valid.
  input wire logic              s_axi_bready,   // Write response ready.
  input wire logic              s_axi_arvalid,  // Read address valid.
  input wire logic              s_axi_arready,  // Read address ready.
  input wire logic [31:0]       s_axi_rdata,    // Read data.
  input wire logic [1:0]        s_axi_rresp,    // Read response.
  input wire logic              s_axi_rvalid,   // Read data valid.
  input wire logic              s_axi_rready,   // Read data ready.
  input wire logic              fault_irq       // Interrupt.
);
  // ---------------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------------
  logic [3:0] q_evt_q;
  logic [3:0] q_wr_q;

  // Saturating ages of the last detector activity and the last write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_evt_q <= 4'hf;
      q_wr_q  <= 4'hf;
    end else begin
      q_evt_q <= (|fault_evt) ? 4'h0 : q_evt_q + {3'h0, q_evt_q != 4'hf};
      q_wr_q  <= (s_axi_awvalid && s_axi_awready) ? 4'h0 : q_wr_q + {3'h0, q_wr_q != 4'hf};
    end
  end

  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A clear-all write once the detectors have long been quiet.
  sequence clr_all;
    wr_pair ##0 (s_axi_awaddr == SMIS_OFF_MSC && s_axi_wdata[6:0] == 7'h7f && s_axi_wstrb[0]
                 && q_evt_q >= 4'hc);
  endsequence

  AST_RST_IRQ: assert property ($rose(aresetn) |-> !fault_irq)
    else $error("interrupt high right after reset");
  AST_B_ANS: assert property (wr_pair |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
                               s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed while waiting");
  AST_RSV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
    else $error("reserved read bits not zero");
  AST_IRQ_RISE: assert property ($rose(fault_irq) |-> q_evt_q < 4'ha || q_wr_q < 4'h6)
    else $error("interrupt rose without a cause");
  AST_IRQ_FALL: assert property ($fell(fault_irq) |-> q_wr_q < 4'h6)
    else $error("interrupt fell without a write");
  AST_IRQ_CLEAR: assert property (clr_all |-> ##[1:3] !fault_irq)
    else $error("interrupt stayed after clear-all");
endmodule

bind smis_top smis_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// *** test/smis_fault_src.sv ***
// Model of the on-chip fault detectors feeding the block.
// Assumes the bench pulses one request bit per event and sets the length.
`timescale 1ns/1ps
module smis_fault_src
  import smis_pkg::*;
(
  input  wire logic       aclk,     // Clock.
  input  wire logic       aresetn,  // Reset, active low.
  input  wire logic [6:0] fire,     // Start an event per source.
  input  wire logic [7:0] dur,      // Event length in cycles.
  output smis_evt_t       evt       // Detector levels, active high.
);
  logic [7:0] cnt_q [7];
  logic [6:0] lvl;

  // Each source holds its level for the asked length, then idles low.
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 7; i++) begin
      if (!aresetn) begin
        cnt_q[i] <= 8'h00;
      end else if (fire[i]) begin
        cnt_q[i] <= dur;
      end else if (cnt_q[i] != 8'h00) begin
        cnt_q[i] <= cnt_q[i] - 8'h01;
      end
    end
  end

  // Levels are whatever the counters say, so no stale value lingers.
  always_comb begin
    lvl = '0;
    for (int i = 0; i < 7; i++) begin
      lvl[i] = (cnt_q[i] != 8'h00);
    end
  end
  assign evt = lvl;
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the masked fault status block.
// Assumes the checker is bound to the top and the detector model drives events.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top
  import smis_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, fault_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, b, v;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bexp;
  logic [33:0] rexp;
  logic [6:0]  fire;
  logic [7:0]  dur;
  smis_evt_t   fault_evt;
  int          n_errors, checked, seed;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];

  smis_top u_dut (.*);
  smis_fault_src u_src (.aclk(aclk), .aresetn(aresetn), .fire(fire), .dur(dur), .evt(fault_evt));

  // ---------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    bq.push_back(e);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!((!s_axi_awvalid || s_axi_awready) && (!s_axi_wvalid || s_axi_wready)));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    rq.push_back({e, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Start one detector event and let it pass the input filter.
  task automatic ev(input int i, input logic [7:0] n);
    @(posedge aclk);
    fire <= 7'(1 << i);
    dur  <= n;
    @(posedge aclk);
    fire <= 7'h00;
    repeat (14) @(posedge aclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Clock at 25 MHz.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Responses are matched against the oldest note in each queue.
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      bexp = bq.pop_front();
      `CHK("bresp", bexp, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rexp = rq.pop_front();
      `CHK("rresp", rexp[33:32], s_axi_rresp)
      `CHK("rdata", rexp[31:0], s_axi_rdata)
    end
  end

  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict;
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    fire = 7'h00;
    dur = 8'h00;
    n_errors = 0;
    checked = 0;
    seed = 74734;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SMIS_OFF_MASK, 32'h0000_0000, SMIS_RESP_OKAY);
    rd(SMIS_OFF_MSC, 32'h0000_0000, SMIS_RESP_OKAY);
    rd(12'h100, 32'h0000_0000, SMIS_RESP_SLVERR);
    wr(12'h100, 32'h0000_007f, SMIS_RESP_SLVERR);
    wr(SMIS_OFF_RAW, 32'h0000_007f, SMIS_RESP_OKAY);
    rd(SMIS_OFF_RAW, 32'h0000_0000, SMIS_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed) & 32'h0000_007f;
      wr(SMIS_OFF_MASK, v, SMIS_RESP_OKAY);
      rd(SMIS_OFF_MASK, v, SMIS_RESP_OKAY);
    end
    wr(SMIS_OFF_MASK, 32'h0000_0000, SMIS_RESP_OKAY);
    // A write without the low byte lane leaves the mask alone.
    s_axi_wstrb <= 4'he;
    wr(SMIS_OFF_MASK, 32'h0000_007f, SMIS_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(SMIS_OFF_MASK, 32'h0000_0000, SMIS_RESP_OKAY);
    // Every source: set, hidden by the mask, shown, kept by a zero write, cleared.
    for (int i = 0; i < 7; i++) begin
      b = 32'h0000_0001 << i;
      ev(i, 8'h04);
      rd(SMIS_OFF_RAW, b, SMIS_RESP_OKAY);
      rd(SMIS_OFF_MSC, 32'h0000_0000, SMIS_RESP_OKAY);
      `CHK("irq", 1'b0, fault_irq)
      wr(SMIS_OFF_MASK, b, SMIS_RESP_OKAY);
      rd(SMIS_OFF_MSC, b, SMIS_RESP_OKAY);
      `CHK("irq", 1'b1, fault_irq)
      wr(SMIS_OFF_MSC, 32'h0000_0000, SMIS_RESP_OKAY);
      rd(SMIS_OFF_MSC, b, SMIS_RESP_OKAY);
      wr(SMIS_OFF_MSC, b, SMIS_RESP_OKAY);
      rd(SMIS_OFF_RAW, 32'h0000_0000, SMIS_RESP_OKAY);
      `CHK("irq", 1'b0, fault_irq)
      wr(SMIS_OFF_MASK, 32'h0000_0000, SMIS_RESP_OKAY);
    end
    // Brown-out reported only while its reset option is off.
    ev(1, 8'h04);
    wr(SMIS_OFF_MASK, 32'h0000_0002, SMIS_RESP_OKAY);
    wr(SMIS_OFF_BOCTL, 32'h0000_0002, SMIS_RESP_OKAY);
    rd(SMIS_OFF_MSC, 32'h0000_0000, SMIS_RESP_OKAY);
    `CHK("irq", 1'b0, fault_irq)
    wr(SMIS_OFF_BOCTL, 32'h0000_0000, SMIS_RESP_OKAY);
    rd(SMIS_OFF_MSC, 32'h0000_0002, SMIS_RESP_OKAY);
    `CHK("irq", 1'b1, fault_irq)
    // A reset in mid-run drops the interrupt and the mask; the reset option, already off, reads back off.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SMIS_OFF_MASK, 32'h0000_0000, SMIS_RESP_OKAY);
    rd(SMIS_OFF_BOCTL, 32'h0000_0000, SMIS_RESP_OKAY);
    rd(SMIS_OFF_MSC, 32'h0000_0000, SMIS_RESP_OKAY);
    `CHK("irq", 1'b0, fault_irq)
    // A clear while the source is still active loses to the event.
    ev(3, 8'h28);
    wr(SMIS_OFF_MSC, 32'h0000_007f, SMIS_RESP_OKAY);
    rd(SMIS_OFF_RAW, 32'h0000_0008, SMIS_RESP_OKAY);
    wr(SMIS_OFF_MASK, 32'h0000_007f, SMIS_RESP_OKAY);
    repeat (40) @(posedge aclk);
    `CHK("irq", 1'b1, fault_irq)
    wr(SMIS_OFF_MSC, 32'h0000_007f, SMIS_RESP_OKAY);
    rd(SMIS_OFF_RAW, 32'h0000_0000, SMIS_RESP_OKAY);
    `CHK("irq", 1'b0, fault_irq)
    repeat (4) @(posedge aclk);
    give_verdict;
  end
endmodule
